// [rtl/rcs_pkg.sv]
// shared constants, types and helpers for the reset cause sequencer
package rcs_pkg;

  // ==========================================================
  // register map and field layout
  localparam logic [7:0] STATUS_ADDR   = 8'h03;
  localparam int         STATUS_W      = 8;
  localparam int         TO_BIT        = 4;
  localparam int         PD_BIT        = 3;
  localparam int         UPPER_LSB     = 5;
  localparam logic [7:0] UPPER_MASK    = 8'hE0;
  localparam logic [7:0] CAUSE_MASK    = 8'h18;
  localparam logic [7:0] STATUS_RST    = 8'h18;
  localparam logic [7:0] RDATA_NONE    = 8'h00;

  // ==========================================================
  // program counter targets
  localparam int          PC_W         = 13;
  localparam logic [12:0] PC_RESET     = 13'h0000;
  localparam logic [12:0] PC_IRQ_VEC   = 13'h0004;
  localparam logic [12:0] PC_STEP      = 13'h0001;

  // ==========================================================
  // timing
  localparam int POWERUP_DELAY_TIMER_TIME_MS     = 72;
  localparam int RC_PERIOD_NS     = 1000;
  localparam int POWERUP_DELAY_TIMER_TICKS_DFLT  = POWERUP_DELAY_TIMER_TIME_MS * 1000000 / RC_PERIOD_NS;
  localparam int OST_CYCLES       = 1024;
  localparam int PIN_FILTER_DFLT  = 20;
  localparam int TMR_W            = 17;

  // ==========================================================
  // oscillator modes
  localparam logic [1:0] OSC_LOW_POWER_XTAL  = 2'h0;
  localparam logic [1:0] OSC_CRYSTAL         = 2'h1;
  localparam logic [1:0] OSC_HIGH_SPEED_XTAL = 2'h2;
  localparam logic [1:0] OSC_RESISTOR_CAP    = 2'h3;

  // ==========================================================
  // types
  typedef enum logic [3:0] {
    S_RUN  = 4'h1,
    S_POWERUP_DELAY_TIMER = 4'h2,
    S_OST  = 4'h4,
    S_HOLD = 4'h8
  } rcs_state_t;

  typedef enum logic [2:0] {
    K_POR       = 3'h0,
    K_PIN_RUN   = 3'h1,
    K_PIN_SLEEP = 3'h2,
    K_WDT_RUN   = 3'h3,
    K_WDT_WAKE  = 3'h4,
    K_IRQ_WAKE  = 3'h5
  } rcs_kind_t;

  typedef struct packed {
    logic       powerup_delay_enable;
    logic [1:0] osc_mode;
  } rcs_cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rcs_bus_req_t;

  // ==========================================================
  // helpers
  function automatic logic is_wake(input rcs_kind_t k);
    return (k == K_WDT_WAKE) || (k == K_IRQ_WAKE);
  endfunction

  function automatic logic is_xtal(input logic [1:0] m);
    return m != OSC_RESISTOR_CAP;
  endfunction

  // status word after a reset or wake of the given kind
  function automatic logic [7:0] status_after(input rcs_kind_t  k,
                                              input logic [7:0] old);
    logic [7:0] s;
    s = old;
    if (!is_wake(k)) begin
      s = s & ~UPPER_MASK;
    end
    case (k)
      K_POR: begin
        s[TO_BIT] = 1'b1;
        s[PD_BIT] = 1'b1;
      end
      K_PIN_SLEEP, K_IRQ_WAKE: begin
        s[TO_BIT] = 1'b1;
        s[PD_BIT] = 1'b0;
      end
      K_WDT_RUN: begin
        s[TO_BIT] = 1'b0;
        s[PD_BIT] = 1'b1;
      end
      K_WDT_WAKE: begin
        s[TO_BIT] = 1'b0;
        s[PD_BIT] = 1'b0;
      end
      default: begin
        s = s;
      end
    endcase
    return s;
  endfunction

endpackage

// [rtl/rcs_glitch_filter.sv]
// reset pin noise filter: level must hold N samples to pass
`timescale 1ns/1ps
`default_nettype none
module rcs_glitch_filter #(
  parameter int N = 20
) (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_raw_low,
  output logic      o_filt_low
);

  // ==========================================================
  // counter of samples that disagree with the output
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        filt_r;
  logic        filt_nxt;

  always_comb begin
    cnt_nxt  = 16'h0000;
    filt_nxt = filt_r;
    if (i_raw_low != filt_r) begin
      if (cnt_r == 16'(N - 1)) begin
        filt_nxt = i_raw_low;
      end else begin
        cnt_nxt = cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_r  <= 16'h0000;
      // start as pin low: a pin held low must not release the chip early
      filt_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_nxt;
      filt_r <= filt_nxt;
    end
  end

  assign o_filt_low = filt_r;

  // ==========================================================
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  filt_change_a: assert property ($changed(filt_r) |->
    $past(cnt_r) == 16'(N - 1) && $past(i_raw_low) == filt_r)
    else $error("filter output changed before the pulse was wide enough");

endmodule
`default_nettype wire

// [rtl/rcs_tick_counter.sv]
// tick counter used for the power-up delay and oscillator settle
`timescale 1ns/1ps
`default_nettype none
module rcs_tick_counter #(
  parameter int W = 17
) (
  input  wire logic         i_clk,
  input  wire logic         i_sys_rst,
  input  wire logic         i_start,
  input  wire logic         i_tick,
  input  wire logic [W-1:0] i_limit,
  output logic              o_done
);

  // ==========================================================
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         busy_r;
  logic         busy_nxt;
  logic         done_r;
  logic         done_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    if (i_start) begin
      cnt_nxt  = '0;
      busy_nxt = 1'b1;
    end else if (busy_r && i_tick) begin
      if (cnt_r == i_limit - W'(1)) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + W'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign o_done = done_r;

endmodule
`default_nettype wire

// [rtl/rcs_reset_cause_sequencer.sv]
// reset cause sequencer: sorts resets, times release, sets pc and status
// Functional notes
// - distinguish power-on, pin run, pin sleep, watchdog run, watchdog wake
// - reset pin passes a noise filter that ignores short pulses
// - unaffected registers stay as they were except after power-on
// - reload defined values on power-on, pin resets and watchdog run reset
// - watchdog time-out in sleep resumes execution, no reload
// - program counter forced to zero on every true reset kind
// - power-on status: upper three clear, both cause flags set
// - pin reset running: upper three clear, all other bits kept
// - pin reset asleep: upper clear, time-out flag set, power-down clear
// - watchdog run reset: upper clear, time-out clear, power-down set
// - watchdog wake: pc plus one, both cause flags cleared
// - interrupt wake: pc plus one, time-out set, power-down clear
// - interrupt wake with global enable loads the interrupt vector
// - rising supply through threshold creates a power-on reset
// - falling supply never causes an internal reset
// - cause flags readable by software in the status word
// - enabled power-up delay holds reset after power-on on rc ticks
// - settle counter 1024 osc cycles, crystal modes, power-on or wake only
// - pin held past time-outs: start at once on pin release
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module rcs_reset_cause_sequencer #(
  parameter int POWERUP_DELAY_TIMER_TICKS  = rcs_pkg::POWERUP_DELAY_TIMER_TICKS_DFLT,
  parameter int PIN_FILTER  = rcs_pkg::PIN_FILTER_DFLT
) (
  input  wire logic                    i_clk,
  input  wire logic                    i_sys_rst,
  input  wire logic                    i_vdd_ok,
  input  wire logic                    i_ext_reset_pin_n,
  input  wire logic                    i_watchdog_timeout,
  input  wire logic                    i_irq_wake,
  input  wire logic                    i_sleeping,
  input  wire logic                    i_global_irq_enable,
  input  wire rcs_pkg::rcs_cfg_t       i_cfg,
  input  wire logic                    i_rc_tick,
  input  wire logic                    i_osc_tick,
  input  wire logic [rcs_pkg::PC_W-1:0] i_pc_current,
  input  wire rcs_pkg::rcs_bus_req_t   i_bus,
  output logic [7:0]                   o_reg_rdata,
  output logic [rcs_pkg::STATUS_W-1:0] o_status,
  output logic                         o_chip_reset,
  output logic                         o_regs_reload,
  output logic                         o_pc_load,
  output logic [rcs_pkg::PC_W-1:0]     o_pc_value,
  output rcs_pkg::rcs_kind_t           o_reset_kind
);

  // ==========================================================
  // supply edge and filtered pin
  logic vdd_q_r;
  logic por_evt;
  logic pin_low;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      vdd_q_r <= 1'b0;
    end else begin
      vdd_q_r <= i_vdd_ok;
    end
  end

  assign por_evt = i_vdd_ok && !vdd_q_r;

  rcs_glitch_filter #(
    .N (PIN_FILTER)
  ) u_filter (
    .i_clk      (i_clk),
    .i_sys_rst  (i_sys_rst),
    .i_raw_low  (!i_ext_reset_pin_n),
    .o_filt_low (pin_low)
  );

  // ==========================================================
  // timers
  logic powerup_delay_timer_start;
  logic powerup_delay_timer_done;
  logic ost_start;
  logic ost_done;

  rcs_tick_counter #(
    .W (rcs_pkg::TMR_W)
  ) u_powerup_delay_timer (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_start   (powerup_delay_timer_start),
    .i_tick    (i_rc_tick),
    .i_limit   (rcs_pkg::TMR_W'(POWERUP_DELAY_TIMER_TICKS)),
    .o_done    (powerup_delay_timer_done)
  );

  rcs_tick_counter #(
    .W (rcs_pkg::TMR_W)
  ) u_osc_settle_counter (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_start   (ost_start),
    .i_tick    (i_osc_tick),
    .i_limit   (rcs_pkg::TMR_W'(rcs_pkg::OST_CYCLES)),
    .o_done    (ost_done)
  );

  // ==========================================================
  // sequencer
  rcs_pkg::rcs_state_t state_r;
  rcs_pkg::rcs_state_t state_nxt;
  rcs_pkg::rcs_kind_t  kind_r;
  rcs_pkg::rcs_kind_t  kind_nxt;
  logic                apply;
  logic                xtal;

  assign xtal = rcs_pkg::is_xtal(i_cfg.osc_mode);

  always_comb begin
    state_nxt  = state_r;
    kind_nxt   = kind_r;
    apply      = 1'b0;
    powerup_delay_timer_start = 1'b0;
    ost_start  = 1'b0;
    if (por_evt) begin
      kind_nxt = rcs_pkg::K_POR;
      if (i_cfg.powerup_delay_enable) begin
        state_nxt  = rcs_pkg::S_POWERUP_DELAY_TIMER;
        powerup_delay_timer_start = 1'b1;
      end else if (xtal) begin
        state_nxt = rcs_pkg::S_OST;
        ost_start = 1'b1;
      end else begin
        state_nxt = rcs_pkg::S_HOLD;
      end
    end else begin
      case (state_r)
        rcs_pkg::S_RUN: begin
          if (pin_low) begin
            kind_nxt  = i_sleeping ? rcs_pkg::K_PIN_SLEEP
                                   : rcs_pkg::K_PIN_RUN;
            state_nxt = rcs_pkg::S_HOLD;
          end else if (i_watchdog_timeout && !i_sleeping) begin
            kind_nxt  = rcs_pkg::K_WDT_RUN;
            state_nxt = rcs_pkg::S_HOLD;
          end else if (i_sleeping && (i_watchdog_timeout || i_irq_wake)) begin
            kind_nxt = i_watchdog_timeout ? rcs_pkg::K_WDT_WAKE
                                          : rcs_pkg::K_IRQ_WAKE;
            // settle on wake only in crystal modes
            if (xtal) begin
              state_nxt = rcs_pkg::S_OST;
              ost_start = 1'b1;
            end else begin
              apply = 1'b1;
            end
          end
        end
        rcs_pkg::S_POWERUP_DELAY_TIMER: begin
          if (powerup_delay_timer_done) begin
            if (xtal) begin
              state_nxt = rcs_pkg::S_OST;
              ost_start = 1'b1;
            end else begin
              state_nxt = rcs_pkg::S_HOLD;
            end
          end
        end
        rcs_pkg::S_OST: begin
          // pin asserted during a wake settle becomes a sleep pin reset
          if (pin_low && rcs_pkg::is_wake(kind_r)) begin
            kind_nxt = rcs_pkg::K_PIN_SLEEP;
          end
          if (ost_done) begin
            state_nxt = rcs_pkg::S_HOLD;
          end
        end
        rcs_pkg::S_HOLD: begin
          if (pin_low && rcs_pkg::is_wake(kind_r)) begin
            kind_nxt = rcs_pkg::K_PIN_SLEEP;
          end
          // release as soon as the pin is high
          if (!pin_low) begin
            state_nxt = rcs_pkg::S_RUN;
            apply     = 1'b1;
          end
        end
        default: begin
          state_nxt = rcs_pkg::S_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_r <= rcs_pkg::S_HOLD;
      kind_r  <= rcs_pkg::K_POR;
    end else begin
      state_r <= state_nxt;
      kind_r  <= kind_nxt;
    end
  end

  // ==========================================================
  // outputs, status word and register port
  logic [7:0]              status_r;
  logic [7:0]              status_nxt;
  logic [7:0]              rdata_r;
  logic [7:0]              rdata_nxt;
  logic                    chip_rst_r;
  logic                    reload_r;
  logic                    reload_nxt;
  logic                    pc_load_r;
  logic [rcs_pkg::PC_W-1:0] pc_r;
  logic [rcs_pkg::PC_W-1:0] pc_nxt;
  rcs_pkg::rcs_kind_t      kind_out_r;
  logic                    wr_status;

  assign wr_status = i_bus.wr && (i_bus.addr == rcs_pkg::STATUS_ADDR);

  always_comb begin
    status_nxt = status_r;
    pc_nxt     = pc_r;
    reload_nxt = 1'b0;
    // cause flags are read-only to software
    if (wr_status) begin
      status_nxt = (i_bus.wdata & ~rcs_pkg::CAUSE_MASK) |
                   (status_r & rcs_pkg::CAUSE_MASK);
    end
    // latch cause at release, wins over a write
    if (apply) begin
      status_nxt = rcs_pkg::status_after(kind_nxt, status_r);
      reload_nxt = !rcs_pkg::is_wake(kind_nxt);
      if (!rcs_pkg::is_wake(kind_nxt)) begin
        pc_nxt = rcs_pkg::PC_RESET;
      end else if (kind_nxt == rcs_pkg::K_IRQ_WAKE && i_global_irq_enable) begin
        pc_nxt = rcs_pkg::PC_IRQ_VEC;
      end else begin
        pc_nxt = i_pc_current + rcs_pkg::PC_STEP;
      end
    end
    rdata_nxt = rcs_pkg::RDATA_NONE;
    if (i_bus.rd && i_bus.addr == rcs_pkg::STATUS_ADDR) begin
      rdata_nxt = status_r;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      // low bits have no defined power-on value; zero here
      status_r   <= rcs_pkg::STATUS_RST;
      rdata_r    <= rcs_pkg::RDATA_NONE;
      chip_rst_r <= 1'b1;
      reload_r   <= 1'b0;
      pc_load_r  <= 1'b0;
      pc_r       <= rcs_pkg::PC_RESET;
      kind_out_r <= rcs_pkg::K_POR;
    end else begin
      status_r   <= status_nxt;
      rdata_r    <= rdata_nxt;
      // any active source holds chip reset
      chip_rst_r <= (state_nxt != rcs_pkg::S_RUN);
      reload_r   <= reload_nxt;
      pc_load_r  <= apply;
      pc_r       <= pc_nxt;
      kind_out_r <= kind_nxt;
    end
  end

  assign o_reg_rdata   = rdata_r;
  assign o_status      = status_r;
  assign o_chip_reset  = chip_rst_r;
  assign o_regs_reload = reload_r;
  assign o_pc_load     = pc_load_r;
  assign o_pc_value    = pc_r;
  assign o_reset_kind  = kind_out_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  pc_zero_reset_a: assert property (pc_load_r &&
    !rcs_pkg::is_wake(kind_out_r) |-> pc_r == rcs_pkg::PC_RESET)
    else $error("pc not zero after a reset");

  por_status_a: assert property (pc_load_r && kind_out_r == rcs_pkg::K_POR
    |-> status_r[7:3] == 5'h03)
    else $error("power-on status pattern wrong");

  pin_run_status_a: assert property (pc_load_r &&
    kind_out_r == rcs_pkg::K_PIN_RUN |-> status_r[7:5] == 3'h0 &&
    status_r[4:0] == $past(status_r[4:0]))
    else $error("pin run status pattern wrong");

  pin_sleep_status_a: assert property (pc_load_r &&
    kind_out_r == rcs_pkg::K_PIN_SLEEP |-> status_r[7:3] == 5'h02 &&
    status_r[2:0] == $past(status_r[2:0]))
    else $error("pin sleep status pattern wrong");

  wdt_run_status_a: assert property (pc_load_r &&
    kind_out_r == rcs_pkg::K_WDT_RUN |-> status_r[7:3] == 5'h01)
    else $error("watchdog run status pattern wrong");

  wdt_wake_a: assert property (pc_load_r &&
    kind_out_r == rcs_pkg::K_WDT_WAKE |-> status_r[4:3] == 2'h0 &&
    status_r[7:5] == $past(status_r[7:5]) && !reload_r)
    else $error("watchdog wake status or reload wrong");

  irq_wake_a: assert property (pc_load_r &&
    kind_out_r == rcs_pkg::K_IRQ_WAKE |-> status_r[4:3] == 2'h2)
    else $error("interrupt wake status pattern wrong");

  irq_vector_a: assert property (apply && kind_nxt == rcs_pkg::K_IRQ_WAKE &&
    i_global_irq_enable |=> pc_r == rcs_pkg::PC_IRQ_VEC)
    else $error("interrupt vector not loaded");

  reload_kind_a: assert property (reload_r |->
    pc_load_r && !rcs_pkg::is_wake(kind_out_r))
    else $error("reload outside a true reset");

  por_hold_a: assert property ($rose(i_vdd_ok) |-> ##2 chip_rst_r)
    else $error("rising supply did not reset the chip");

  vdd_fall_a: assert property ($fell(i_vdd_ok) && state_r == rcs_pkg::S_RUN
    && !pin_low && !i_watchdog_timeout && !i_irq_wake
    |=> state_r == rcs_pkg::S_RUN)
    else $error("falling supply caused a reset");

  status_read_a: assert property (i_bus.rd &&
    i_bus.addr == rcs_pkg::STATUS_ADDR |=> rdata_r == $past(status_r))
    else $error("status read data wrong");

  powerup_delay_timer_enable_a: assert property (state_r == rcs_pkg::S_POWERUP_DELAY_TIMER |->
    i_cfg.powerup_delay_enable || $past(i_cfg.powerup_delay_enable))
    else $error("power-up delay ran while disabled");

  ost_xtal_a: assert property ($rose(state_r == rcs_pkg::S_OST) |->
    $past(xtal))
    else $error("settle counter ran in resistor-cap mode");

  pin_release_a: assert property (state_r == rcs_pkg::S_HOLD && !pin_low &&
    !por_evt |=> state_r == rcs_pkg::S_RUN ##1 !chip_rst_r)
    else $error("release delayed after pin high");

  release_latch_a: assert property ($fell(chip_rst_r) |-> pc_load_r)
    else $error("cause not latched at release");

  por_seen_c:   cover property (pc_load_r && kind_out_r == rcs_pkg::K_POR);
  pin_sleep_c:  cover property (pc_load_r &&
                                kind_out_r == rcs_pkg::K_PIN_SLEEP);
  wdt_wake_c:   cover property (pc_load_r &&
                                kind_out_r == rcs_pkg::K_WDT_WAKE);
  irq_vector_c: cover property (pc_load_r && pc_r == rcs_pkg::PC_IRQ_VEC);

endmodule
`default_nettype wire

// [dv/rcs_supply_pin_model.sv]
// supply detector and external reset pin model for the sequencer
`timescale 1ns/1ps
`default_nettype none
module rcs_supply_pin_model (
  input  wire logic i_clk,
  output logic      o_vdd_ok,
  output logic      o_ext_reset_pin_n
);
  // ==========================================================
  // power-up state
  // pin low until supply valid
  initial begin
    o_vdd_ok          = 1'b0;
    o_ext_reset_pin_n = 1'b0;
  end

  // ==========================================================
  // supply and pin actions
  // rising supply, pin freed later
  task automatic supply_up(input int d);
    @(posedge i_clk);
    o_vdd_ok <= 1'b1;
    repeat (d) @(posedge i_clk);
    o_ext_reset_pin_n <= 1'b1;
  endtask

  task automatic supply_drop();
    @(posedge i_clk);
    o_vdd_ok <= 1'b0;
  endtask

  // pin low for n cycles: short pulses model noise, longer ones a pin reset
  task automatic pin_pulse(input int n);
    @(posedge i_clk);
    o_ext_reset_pin_n <= 1'b0;
    repeat (n) @(posedge i_clk);
    o_ext_reset_pin_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// [dv/rcs_reset_cause_sequencer_test.sv]
// self-checking bench for the reset cause sequencer
`timescale 1ns/1ps
`default_nettype none
module rcs_reset_cause_sequencer_test;
  localparam int POWERUP_DELAY_TIMER = 8;
  logic                  i_clk     = 1'b0;
  logic                  i_sys_rst = 1'b1;
  logic                  wdt       = 1'b0;
  logic                  irq       = 1'b0;
  logic                  slp       = 1'b0;
  logic                  global_irq_enable       = 1'b0;
  rcs_pkg::rcs_cfg_t     cfg       = 3'h5;
  logic [1:0]            tk        = 2'h0;
  logic                  rc_tick   = 1'b0;
  logic                  osc_tick  = 1'b0;
  logic [12:0]           pc_cur    = 13'h0123;
  rcs_pkg::rcs_bus_req_t bus       = '0;
  logic [7:0]            rdata;
  logic [7:0]            status;
  logic                  chip_rst;
  logic                  reload;
  logic                  pc_load;
  logic [12:0]           pc_val;
  rcs_pkg::rcs_kind_t    kind;
  logic                  vdd;
  logic                  pin_n;
  logic [7:0]            st        = 8'h18;
  int                    n_fail    = 0;
  int                    check_count = 0;
  int                    hc;

  always #5 i_clk = ~i_clk;

  // rc time base two times slower than the oscillator ticks
  always @(posedge i_clk) begin
    tk       <= tk + 2'h1;
    rc_tick  <= (tk == 2'h3);
    osc_tick <= ~osc_tick;
  end

  rcs_supply_pin_model u_rcs_supply_pin_model (
    .i_clk             (i_clk),
    .o_vdd_ok          (vdd),
    .o_ext_reset_pin_n (pin_n)
  );

  rcs_reset_cause_sequencer #(.POWERUP_DELAY_TIMER_TICKS(POWERUP_DELAY_TIMER), .PIN_FILTER(3))
    u_rcs_reset_cause_sequencer (
    .i_clk (i_clk), .i_sys_rst (i_sys_rst), .i_vdd_ok (vdd),
    .i_ext_reset_pin_n (pin_n), .i_watchdog_timeout (wdt),
    .i_irq_wake (irq), .i_sleeping (slp), .i_global_irq_enable (global_irq_enable),
    .i_cfg (cfg), .i_rc_tick (rc_tick), .i_osc_tick (osc_tick),
    .i_pc_current (pc_cur), .i_bus (bus), .o_reg_rdata (rdata),
    .o_status (status), .o_chip_reset (chip_rst),
    .o_regs_reload (reload), .o_pc_load (pc_load), .o_pc_value (pc_val),
    .o_reset_kind (kind)
  );

  // ==========================================================
  // shared checks and bus cycles
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    bus <= '0;
    if (a == rcs_pkg::STATUS_ADDR) st = (d & 8'hE7) | (st & 8'h18);
    #1;
    chk("status_wr", 16'(st), 16'(status));
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    bus <= '0;
    #1;
    chk("rdata", 16'(e), 16'(rdata));
  endtask

  // wait for release and judge what it carries; hc counts reset cycles
  task automatic wait_rel(input logic [2:0] k, input logic [12:0] pc,
                          input logic rl, input logic [7:0] m);
    int n;
    n  = 0;
    hc = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
      if (chip_rst === 1'b1) hc++;
    end while (pc_load !== 1'b1 && n < 3000);
    chk("pc_load", 16'h1, 16'(pc_load));
    chk("chip_reset", 16'h0, 16'(chip_rst));
    chk("pc_value", 16'(pc), 16'(pc_val));
    chk("kind", 16'(k), 16'(kind));
    chk("reload", 16'(rl), 16'(reload));
    chk("status", 16'(st & m), 16'(status & m));
  endtask

  task automatic quiet(input int n, input string nm);
    logic acc;
    acc = 1'b0;
    repeat (n) begin
      @(posedge i_clk);
      #1;
      acc = acc | chip_rst;
    end
    chk(nm, 16'h0, 16'(acc));
  endtask

  // ==========================================================
  // scenarios
  // pin held past both time-outs: start right after release
  task automatic t_por_xtal();
    st = {3'h0, 2'h3, st[2:0]};
    fork
      u_rcs_supply_pin_model.supply_up(2500);
      wait_rel(3'h0, 13'h0000, 1'b1, 8'hF8);
    join
    chk("hold_pin", 16'h1, 16'(hc >= 2500 && hc <= 2512));
  endtask

  task automatic t_por_rc();
    cfg <= 3'h7;
    u_rcs_supply_pin_model.supply_drop();
    quiet(6, "fall_reset");
    st = {3'h0, 2'h3, st[2:0]};
    fork
      u_rcs_supply_pin_model.supply_up(0);
      wait_rel(3'h0, 13'h0000, 1'b1, 8'hF8);
    join
    chk("rc_hold", 16'h1, 16'(hc >= 28 && hc <= 45));
  endtask

  task automatic t_bus();
    bus_wr(8'h03, 8'hFF);
    bus_rd(8'h03, st);
    bus_wr(8'h05, 8'h00);
    bus_rd(8'h05, 8'h00);
  endtask

  task automatic t_pin_run();
    u_rcs_supply_pin_model.pin_pulse(2);
    quiet(8, "glitch");
    u_rcs_supply_pin_model.pin_pulse(6);
    st = st & 8'h1F;
    wait_rel(3'h1, 13'h0000, 1'b1, 8'hFF);
  endtask

  task automatic t_wdt_run();
    @(posedge i_clk);
    wdt <= 1'b1;
    @(posedge i_clk);
    wdt <= 1'b0;
    st = {3'h0, 2'h1, st[2:0]};
    wait_rel(3'h3, 13'h0000, 1'b1, 8'hFF);
  endtask

  // wakes keep the upper bits, so they are set beforehand
  task automatic t_wake(input logic by_irq, input logic g,
                        input logic [12:0] pc);
    @(posedge i_clk);
    slp    <= 1'b1;
    global_irq_enable    <= g;
    pc_cur <= pc_cur + 13'h0100;
    @(posedge i_clk);
    wdt <= ~by_irq;
    irq <= by_irq;
    @(posedge i_clk);
    wdt <= 1'b0;
    irq <= 1'b0;
    st = (st & 8'hE7) | (by_irq ? 8'h10 : 8'h00);
    wait_rel(by_irq ? 3'h5 : 3'h4, pc, 1'b0, 8'hFF);
    slp <= 1'b0;
  endtask

  task automatic t_pin_sleep();
    @(posedge i_clk);
    slp <= 1'b1;
    u_rcs_supply_pin_model.pin_pulse(6);
    st = {3'h0, 2'h2, st[2:0]};
    wait_rel(3'h2, 13'h0000, 1'b1, 8'hFF);
    slp <= 1'b0;
  endtask

  // ==========================================================
  // main sequence and hang guard
  initial begin
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_por_xtal();
    t_bus();
    t_pin_run();
    bus_wr(8'h03, 8'hFF);
    t_wdt_run();
    bus_wr(8'h03, 8'hE5);
    t_wake(1'b0, 1'b1, 13'h0224);
    t_wake(1'b1, 1'b0, 13'h0324);
    t_wake(1'b1, 1'b1, 13'h0004);
    t_pin_sleep();
    t_por_rc();
    give_verdict();
  end

  // whole run needs about 9000 cycles
  initial begin
    repeat (40000) @(posedge i_clk);
    n_fail++;
    $display("BAD watchdog exp done got hang");
    give_verdict();
  end
endmodule
`default_nettype wire
